// [shared/synth_cfg_pkg.sv]
// Overview of operation
// RL1 - each rising serial clock edge shifts the data pin into a 24-bit shift register.
// RL2 - a rising load strobe copies the shift register into the latch that the word selects.
// RL3 - the host keeps the serial clock at or below 20 MHz.
// RL4 - chip enable high means normal operation; low holds the device in hardware power-down.
// RL5 - the reference buffer force-on pin enables the buffer output regardless of anything else.
// RL6 - the enabled reference buffer output is a buffered copy of the reference input.
// RL7 - one serial word alone is enough to change the output frequency.
// RL8 - the modulator order is programmable from first to fourth order.
// RL9 - the fractional modulus width is programmable as 12 or 22 bits.
// RL10 - RF prescaler 16/17/20/21 or 32/33/36/37, IF prescaler 8/9 or 16/17, by setting.
// RL11 - the test-or-lock pin shows a test frequency or lock detect, as configured.
// RL12 - the fastlock pin can also be a programmable CMOS output or high impedance.
// RL13 - the host holds the strobe low over 24 bits, MSB first, raising it after the last edge.
package synth_cfg_pkg;
    localparam int WORD_W = 24;
    localparam int CNT_W = 5;
    localparam int DATA_W = 22;
    localparam int DATA_LSB = 2;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [1:0] LATCH_FREQ = 2'h0;
    localparam logic [1:0] LATCH_MOD = 2'h1;
    localparam logic [1:0] LATCH_OUT = 2'h2;
    localparam logic [1:0] LATCH_PWR = 2'h3;
    // modulator latch fields
    localparam int MOD_ORDER_LSB = 2;
    localparam int MOD_FRAC22_BIT = 4;
    localparam int MOD_RFPRE_BIT = 5;
    localparam int MOD_IFPRE_BIT = 6;
    // output latch fields
    localparam int OUT_LOCKSEL_BIT = 2;
    localparam int OUT_FLMODE_LSB = 3;
    localparam int OUT_REFEN_BIT = 5;
    localparam int OUT_TAP_LSB = 6;
    // power latch field
    localparam int PWR_PD_BIT = 2;
    localparam logic [1:0] FL_FASTLOCK = 2'h0;
    localparam logic [1:0] FL_CMOS_LOW = 2'h1;
    localparam logic [1:0] FL_CMOS_HIGH = 2'h2;
    localparam logic [1:0] FL_TRISTATE = 2'h3;
    localparam int TEST_CNT_W = 8;

    typedef struct packed {
        logic [1:0] order;
        logic frac22;
        logic rf_pre32;
        logic if_pre16;
    } mod_cfg_t;

    typedef struct packed {
        logic lock_sel;
        logic [1:0] fl_mode;
        logic ref_en;
        logic [2:0] test_tap;
    } out_cfg_t;

    typedef struct packed {
        logic fastlock_req;
        logic lock_det;
        logic ref_in;
        logic force_on;
        logic ce;
        logic le;
        logic sdata;
        logic sclk;
    } pins_t;

    localparam mod_cfg_t MOD_RESET = '0;
    localparam out_cfg_t OUT_RESET = '0;
    localparam logic [DATA_W-1:0] FREQ_RESET = 22'h00_0000;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int SCLK_MAX_MHZ = 20;
    localparam int SCLK_MIN_CYC = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
    localparam int GAP_W = 4;

    // register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MOD = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OUT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LOADS = 8'h14;
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_FREQ = 3'h2;
    localparam logic [2:0] IDX_MOD = 3'h3;
    localparam logic [2:0] IDX_OUT = 3'h4;
    localparam logic [2:0] IDX_LOADS = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam int CTRL_PORTEN_BIT = 0;
    localparam logic CTRL_PORTEN_RESET = 1'b1;
    localparam int ST_CE_BIT = 0;
    localparam int ST_FORCE_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    localparam int ST_FAST_BIT = 4;
    localparam int ST_SHORT_BIT = 5;
    localparam int ST_REFUSED_BIT = 6;
    localparam int LOADS_W = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL: reg_index = IDX_CTRL;
            OFS_STATUS: reg_index = IDX_STATUS;
            OFS_FREQ: reg_index = IDX_FREQ;
            OFS_MOD: reg_index = IDX_MOD;
            OFS_OUT: reg_index = IDX_OUT;
            OFS_LOADS: reg_index = IDX_LOADS;
            default: reg_index = IDX_NONE;
        endcase
    endfunction : reg_index
endpackage : synth_cfg_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : pin_sync

// [hdl/serial_shifter.sv]
`timescale 1ns/1ps
module serial_shifter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic le,
    output logic sclk_rise,
    output logic load_pulse,
    output logic [synth_cfg_pkg::WORD_W-1:0] load_word,
    output logic [synth_cfg_pkg::CNT_W-1:0] load_bits
);
    localparam int CNT_W = synth_cfg_pkg::CNT_W;
    logic sclk_d_r;
    logic le_d_r;
    logic le_rise;
    logic [synth_cfg_pkg::WORD_W-1:0] shift_r;
    logic [synth_cfg_pkg::CNT_W-1:0] cnt_r;

    assign sclk_rise = sclk & ~sclk_d_r;
    assign le_rise = le & ~le_d_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_r <= 1'b0;
            le_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
            le_d_r <= le;
        end
    end

    // msb first: oldest bit ends at the top
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_r <= '0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[synth_cfg_pkg::WORD_W-2:0], sdata}; // RL1
        end
    end

    // bits seen since the last strobe, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else if (le_rise) begin
            cnt_r <= '0;
        end else if (sclk_rise && cnt_r != CNT_W'(synth_cfg_pkg::WORD_W + 1)) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_pulse <= 1'b0;
            load_word <= '0;
            load_bits <= '0;
        end else begin
            load_pulse <= le_rise; // RL2
            if (le_rise) begin
                load_word <= shift_r;
                load_bits <= cnt_r;
            end
        end
    end
endmodule : serial_shifter

// [hdl/synth_serial_config_port.sv]
`timescale 1ns/1ps
module synth_serial_config_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [synth_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [synth_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic latch_load_strobe,
    input wire logic chip_enable,
    input wire logic ref_buffer_force_on,
    input wire logic ref_input,
    input wire logic lock_detect_in,
    input wire logic fastlock_request,
    output logic ref_buffer_output,
    output logic test_or_lock_output,
    output logic fastlock_output_pin_out,
    output logic fastlock_output_pin_oe,
    output logic power_down,
    output logic [synth_cfg_pkg::DATA_W-1:0] freq_word,
    output logic freq_update,
    output synth_cfg_pkg::mod_cfg_t mod_cfg
);
    localparam int DW = synth_cfg_pkg::DATA_W;
    localparam int LW = synth_cfg_pkg::LOADS_W;
    localparam int GW = synth_cfg_pkg::GAP_W;
    localparam int TW = synth_cfg_pkg::TEST_CNT_W;

    synth_cfg_pkg::pins_t pins_raw;
    synth_cfg_pkg::pins_t pins_s;
    logic sclk_rise, load_pulse, load_ok;
    logic [synth_cfg_pkg::WORD_W-1:0] load_word;
    logic [synth_cfg_pkg::CNT_W-1:0] load_bits;
    logic [synth_cfg_pkg::SEL_W-1:0] load_sel;
    logic [DW-1:0] load_data;

    assign pins_raw = '{fastlock_req: fastlock_request, lock_det: lock_detect_in,
                        ref_in: ref_input, force_on: ref_buffer_force_on,
                        ce: chip_enable, le: latch_load_strobe,
                        sdata: serial_data, sclk: serial_clock};

    pin_sync #(
        .W($bits(synth_cfg_pkg::pins_t))
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    serial_shifter u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .sclk(pins_s.sclk),
        .sdata(pins_s.sdata),
        .le(pins_s.le),
        .sclk_rise(sclk_rise),
        .load_pulse(load_pulse),
        .load_word(load_word),
        .load_bits(load_bits)
    );

    // latches and register state
    logic [DW-1:0] freq_r;
    logic freq_update_r, sw_pd_r, port_en_r;
    synth_cfg_pkg::mod_cfg_t mod_r;
    synth_cfg_pkg::out_cfg_t out_r;
    logic [LW-1:0] loads_r;
    logic fast_flag_r, short_flag_r, refused_flag_r;
    logic [GW-1:0] gap_r;
    logic gap_valid_r;
    assign load_sel = load_word[synth_cfg_pkg::SEL_LSB +: synth_cfg_pkg::SEL_W];
    assign load_data = load_word[synth_cfg_pkg::DATA_LSB +: DW];
    assign load_ok = load_pulse & port_en_r;

    // strobe edge transfers the word into its latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_r <= synth_cfg_pkg::FREQ_RESET;
            mod_r <= synth_cfg_pkg::MOD_RESET;
            out_r <= synth_cfg_pkg::OUT_RESET;
            sw_pd_r <= 1'b0;
        end else if (load_ok) begin // RL2
            case (load_sel)
                synth_cfg_pkg::LATCH_FREQ: freq_r <= load_data; // RL7
                synth_cfg_pkg::LATCH_MOD: begin
                    mod_r.order <= load_word[synth_cfg_pkg::MOD_ORDER_LSB +: 2]; // RL8
                    mod_r.frac22 <= load_word[synth_cfg_pkg::MOD_FRAC22_BIT]; // RL9
                    mod_r.rf_pre32 <= load_word[synth_cfg_pkg::MOD_RFPRE_BIT]; // RL10
                    mod_r.if_pre16 <= load_word[synth_cfg_pkg::MOD_IFPRE_BIT]; // RL10
                end
                synth_cfg_pkg::LATCH_OUT: begin
                    out_r.lock_sel <= load_word[synth_cfg_pkg::OUT_LOCKSEL_BIT];
                    out_r.fl_mode <= load_word[synth_cfg_pkg::OUT_FLMODE_LSB +: 2];
                    out_r.ref_en <= load_word[synth_cfg_pkg::OUT_REFEN_BIT];
                    out_r.test_tap <= load_word[synth_cfg_pkg::OUT_TAP_LSB +: 3];
                end
                default: sw_pd_r <= load_word[synth_cfg_pkg::PWR_PD_BIT];
            endcase
        end
    end

    // one pulse per frequency word, no second word needed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_update_r <= 1'b0;
        end else begin
            freq_update_r <= load_ok && load_sel == synth_cfg_pkg::LATCH_FREQ; // RL7
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loads_r <= '0;
        end else if (load_ok) begin
            loads_r <= loads_r + LW'(1);
        end
    end

    // edge spacing watch; one cycle of slack covers synchroniser jitter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_r <= '0;
            gap_valid_r <= 1'b0;
        end else if (sclk_rise) begin
            gap_r <= '0;
            gap_valid_r <= 1'b1;
        end else begin
            if (gap_r != GW'(synth_cfg_pkg::SCLK_MIN_CYC)) begin
                gap_r <= gap_r + GW'(1);
            end
            if (load_pulse) begin
                gap_valid_r <= 1'b0;
            end
        end
    end

    // register bus: write path
    logic aw_got_r, w_got_r;
    logic [synth_cfg_pkg::ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_hs, w_hs, wr_fire, st_wr;
    logic [2:0] wr_idx;
    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign wr_fire = aw_got_r & w_got_r & ~bvalid;
    assign wr_idx = synth_cfg_pkg::reg_index(waddr_r);
    assign st_wr = wr_fire && wr_idx == synth_cfg_pkg::IDX_STATUS && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            if (aw_hs) begin
                waddr_r <= awaddr;
            end
            if (w_hs) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            aw_got_r <= (aw_got_r | aw_hs) & ~wr_fire;
            w_got_r <= (w_got_r | w_hs) & ~wr_fire;
            awready <= ~((aw_got_r | aw_hs) & ~wr_fire);
            wready <= ~((w_got_r | w_hs) & ~wr_fire);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= synth_cfg_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (wr_idx == synth_cfg_pkg::IDX_NONE) ? synth_cfg_pkg::RESP_SLVERR
                                                          : synth_cfg_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_en_r <= synth_cfg_pkg::CTRL_PORTEN_RESET;
        end else if (wr_fire && wr_idx == synth_cfg_pkg::IDX_CTRL && wstrb_r[0]) begin
            port_en_r <= wdata_r[synth_cfg_pkg::CTRL_PORTEN_BIT];
        end
    end

    // sticky flags: a new event beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_flag_r <= 1'b0;
            short_flag_r <= 1'b0;
            refused_flag_r <= 1'b0;
        end else begin
            if (sclk_rise && gap_valid_r
                && gap_r < GW'(synth_cfg_pkg::SCLK_MIN_CYC - 2)) begin
                fast_flag_r <= 1'b1; // RL3
            end else if (st_wr && wdata_r[synth_cfg_pkg::ST_FAST_BIT]) begin
                fast_flag_r <= 1'b0;
            end
            if (load_pulse && load_bits != synth_cfg_pkg::CNT_W'(synth_cfg_pkg::WORD_W)) begin
                short_flag_r <= 1'b1; // RL13
            end else if (st_wr && wdata_r[synth_cfg_pkg::ST_SHORT_BIT]) begin
                short_flag_r <= 1'b0;
            end
            if (load_pulse && !port_en_r) begin
                refused_flag_r <= 1'b1;
            end else if (st_wr && wdata_r[synth_cfg_pkg::ST_REFUSED_BIT]) begin
                refused_flag_r <= 1'b0;
            end
        end
    end

    // register bus: read path, answer on the same edge that takes the address
    logic ar_hs;
    logic [31:0] status_word, rd_mux;
    assign ar_hs = arvalid & arready;

    always_comb begin
        status_word = '0;
        status_word[synth_cfg_pkg::ST_CE_BIT] = pins_s.ce;
        status_word[synth_cfg_pkg::ST_FORCE_BIT] = pins_s.force_on;
        status_word[synth_cfg_pkg::ST_PD_BIT] = power_down;
        status_word[synth_cfg_pkg::ST_LOCK_BIT] = pins_s.lock_det;
        status_word[synth_cfg_pkg::ST_FAST_BIT] = fast_flag_r;
        status_word[synth_cfg_pkg::ST_SHORT_BIT] = short_flag_r;
        status_word[synth_cfg_pkg::ST_REFUSED_BIT] = refused_flag_r;
        case (synth_cfg_pkg::reg_index(araddr))
            synth_cfg_pkg::IDX_CTRL: rd_mux = 32'(port_en_r);
            synth_cfg_pkg::IDX_STATUS: rd_mux = status_word;
            synth_cfg_pkg::IDX_FREQ: rd_mux = 32'(freq_r);
            synth_cfg_pkg::IDX_MOD: rd_mux = 32'(mod_r);
            synth_cfg_pkg::IDX_OUT: rd_mux = 32'(out_r);
            synth_cfg_pkg::IDX_LOADS: rd_mux = 32'(loads_r);
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= synth_cfg_pkg::RESP_OKAY;
            arready <= 1'b0;
        end else begin
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= (synth_cfg_pkg::reg_index(araddr) == synth_cfg_pkg::IDX_NONE)
                         ? synth_cfg_pkg::RESP_SLVERR : synth_cfg_pkg::RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
            arready <= ~(ar_hs | (rvalid & ~rready));
        end
    end

    // pin outputs
    logic pd_nxt;
    logic [TW-1:0] test_cnt_r;

    assign pd_nxt = ~pins_s.ce | sw_pd_r; // RL4

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_cnt_r <= '0;
        end else begin
            test_cnt_r <= test_cnt_r + TW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down <= 1'b1;
            ref_buffer_output <= 1'b0;
            test_or_lock_output <= 1'b0;
        end else begin
            power_down <= pd_nxt; // RL4
            // force-on outranks power-down and the programmed enable
            ref_buffer_output <= (pins_s.force_on | (~pd_nxt & out_r.ref_en)) // RL5
                                 & pins_s.ref_in; // RL6
            if (pd_nxt) begin
                test_or_lock_output <= 1'b0;
            end else if (out_r.lock_sel) begin
                test_or_lock_output <= pins_s.lock_det; // RL11
            end else begin
                test_or_lock_output <= test_cnt_r[out_r.test_tap]; // RL11
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fastlock_output_pin_out <= 1'b0;
            fastlock_output_pin_oe <= 1'b0;
        end else if (pd_nxt) begin
            fastlock_output_pin_out <= 1'b0;
            fastlock_output_pin_oe <= 1'b0;
        end else begin
            fastlock_output_pin_oe <= out_r.fl_mode != synth_cfg_pkg::FL_TRISTATE; // RL12
            case (out_r.fl_mode) // RL12
                synth_cfg_pkg::FL_FASTLOCK: fastlock_output_pin_out <= pins_s.fastlock_req;
                synth_cfg_pkg::FL_CMOS_HIGH: fastlock_output_pin_out <= 1'b1;
                default: fastlock_output_pin_out <= 1'b0;
            endcase
        end
    end

    assign freq_word = freq_r;
    assign freq_update = freq_update_r;
    assign mod_cfg = mod_r;
endmodule : synth_serial_config_port

// [dv/host_serial_model.sv]
`timescale 1ns/1ps
module host_serial_model (
    input wire logic aclk,
    output logic sclk,
    output logic sdata,
    output logic le
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        le = 1'b0;
    end
    // clock parks low outside frames
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            sdata <= w[i];
            repeat (4) @(posedge aclk);
            sclk <= 1'b1;
            repeat (4) @(posedge aclk);
            sclk <= 1'b0;
        end
        // data line must not keep the last bit
        sdata <= ~w[0];
        repeat (4) @(posedge aclk);
        le <= 1'b1;
        repeat (8) @(posedge aclk);
        le <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : send
endmodule : host_serial_model

// [dv/synth_serial_config_port_checker.sv]
`timescale 1ns/1ps
module synth_cfg_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic chip_enable,
    input wire logic power_down,
    input wire logic test_or_lock_output,
    input wire logic fastlock_output_pin_oe,
    input wire logic [synth_cfg_pkg::DATA_W-1:0] freq_word,
    input wire logic freq_update,
    input wire synth_cfg_pkg::mod_cfg_t mod_cfg,
    input wire logic latch_load_strobe,
    input wire logic ref_buffer_force_on,
    input wire logic ref_input,
    input wire logic ref_buffer_output
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    pd_ce_a: assert property (!chip_enable [*5] |-> power_down)
        else $error("no power-down with enable low");
    pd_out_a: assert property (power_down [*2] |-> !test_or_lock_output && !fastlock_output_pin_oe)
        else $error("outputs active in power-down");
    upd_cause_a: assert property ($changed(freq_word) |-> ##[0:1] freq_update)
        else $error("no update pulse");
    le_cause_a: assert property (($changed(freq_word) || $changed(mod_cfg)) |-> $past(latch_load_strobe))
        else $error("latch changed without strobe");
    le_quiet_a: assert property (!latch_load_strobe [*8] |=> $stable(freq_word) && $stable(mod_cfg))
        else $error("latch drifted");
    b_taken_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    r_taken_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    ref_force_a: assert property ((ref_buffer_force_on && $stable(ref_input)) [*6] |-> ref_buffer_output == ref_input)
        else $error("forced buffer not copying");
    ref_off_a: assert property ((power_down && !ref_buffer_force_on) [*4] |-> !ref_buffer_output)
        else $error("buffer on in power-down");
    cover property (freq_update);
    cover property (ref_buffer_force_on && power_down && ref_buffer_output);
    cover property (bvalid && bready);
endmodule : synth_cfg_checker

bind synth_serial_config_port synth_cfg_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .rvalid(rvalid),
    .rready(rready), .chip_enable(chip_enable), .power_down(power_down),
    .test_or_lock_output(test_or_lock_output), .fastlock_output_pin_oe(fastlock_output_pin_oe),
    .freq_word(freq_word), .freq_update(freq_update), .mod_cfg(mod_cfg),
    .latch_load_strobe(latch_load_strobe), .ref_buffer_force_on(ref_buffer_force_on),
    .ref_input(ref_input), .ref_buffer_output(ref_buffer_output));

// [dv/tb_synth_serial_config_port.sv]
`timescale 1ns/1ps
module tb_synth_serial_config_port;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sclk, sdata, le;
    logic [1:0] bresp, rresp, fl;
    logic ce = 1'b1, force_on = 1'b0, ref_in = 1'b0, lock_in = 1'b0, fl_req = 1'b0;
    logic ref_out, test_out, fl_out, fl_oe, pd, upd;
    logic [21:0] freq;
    logic [4:0] m;
    synth_cfg_pkg::mod_cfg_t mod;
    int n_errors = 0, total_checks = 0;
    always #5 aclk = ~aclk;
    host_serial_model i_host (.aclk(aclk), .sclk(sclk), .sdata(sdata), .le(le));
    synth_serial_config_port i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_clock(sclk), .serial_data(sdata), .latch_load_strobe(le), .chip_enable(ce),
        .ref_buffer_force_on(force_on), .ref_input(ref_in), .lock_detect_in(lock_in),
        .fastlock_request(fl_req), .ref_buffer_output(ref_out), .test_or_lock_output(test_out),
        .fastlock_output_pin_out(fl_out), .fastlock_output_pin_oe(fl_oe), .power_down(pd),
        .freq_word(freq), .freq_update(upd), .mod_cfg(mod));
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic limit(input int n);
        if (n >= 100) begin
            n_errors++;
            end_of_test();
        end
    endtask : limit
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        limit(n);
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        limit(n);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
    endtask : rc
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rc(synth_cfg_pkg::OFS_CTRL, 32'h0000_0001, 2'h0);
        rc(synth_cfg_pkg::OFS_FREQ, 32'h0000_0000, 2'h0);
        i_host.send({22'h2A_5A5C, 2'h0});
        chk(32'(freq), 32'h002A_5A5C);
        rc(synth_cfg_pkg::OFS_LOADS, 32'h0000_0001, 2'h0);
        $display("test freq done");
        for (int i = 0; i < 4; i++) begin
            m = {i[1:0], i[0], i[1], !i[0]};
            i_host.send({17'h0_0000, m[0], m[1], m[2], m[4:3], 2'h1});
            chk(32'(mod), 32'(m));
            rc(synth_cfg_pkg::OFS_MOD, 32'(m), 2'h0);
        end
        $display("test modulator done");
        for (int i = 0; i < 4; i++) begin
            fl = i[1:0];
            fl_req <= (fl != 2'h2);
            lock_in <= fl[0];
            i_host.send({15'h0000, 3'h5, 1'b1, fl, 1'b1, 2'h2});
            chk({fl_oe, fl_out & fl_oe, test_out}, {fl != 2'h3, !fl[0], fl[0]});
            rc(synth_cfg_pkg::OFS_OUT, {25'h000_0000, 1'b1, fl, 1'b1, 3'h5}, 2'h0);
        end
        $display("test outputs done");
        ref_in <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(ref_out), 32'h0000_0001);
        i_host.send({21'h00_0000, 1'b1, 2'h3});
        chk({pd, ref_out}, 32'h0000_0002);
        force_on <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(ref_out), 32'h0000_0001);
        ref_in <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(32'(ref_out), 32'h0000_0000);
        force_on <= 1'b0;
        i_host.send({21'h00_0000, 1'b0, 2'h3});
        ce <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({pd, fl_oe, test_out}, 32'h0000_0004);
        ce <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(32'(pd), 32'h0000_0000);
        $display("test power done");
        wr(synth_cfg_pkg::OFS_CTRL, 32'h0000_0000, 2'h0);
        i_host.send({22'h00_0001, 2'h0});
        chk(32'(freq), 32'h002A_5A5C);
        rc(synth_cfg_pkg::OFS_STATUS, 32'h0000_0049, 2'h0);
        wr(synth_cfg_pkg::OFS_STATUS, 32'h0000_0040, 2'h0);
        wr(synth_cfg_pkg::OFS_CTRL, 32'h0000_0001, 2'h0);
        rc(synth_cfg_pkg::OFS_STATUS, 32'h0000_0009, 2'h0);
        rc(8'h18, 32'h0000_0000, 2'h2);
        wr(8'h18, 32'h0000_00FF, 2'h2);
        $display("test bus done");
        end_of_test();
    end
endmodule : tb_synth_serial_config_port
